/* File: sar_adc_control.sv */
// Control logic of the successive-approximation converter with its register set.
// Notes on behaviour
// - First compare against half supply, decide top bit.
// - Then trial bit 8; tap follows bit 9.
// - Keep each bit if input at least tap.
// - Narrow resolution stops after deciding bit two.
// - Resolution select bit in mode register two.
// - One channel chosen; convert only on start.
// - Eleven pins plus reference, temperature, touch sources.
// - External channel count is 4, 7 or 11.
// - Finished approximation is copied into result registers.
// - Conversion end raises the end interrupt request.
// - Wide result left aligned, six low zeros.
// - Byte result holds eight top result bits.
// - Clock enable low: reset state, writes ignored.
// - Clock enable high: registers read and written.
// - Peripheral enable resets zero; bit or byte writes.
// - Unselected analog pins stay ordinary port pins.
// - Run set only with comparator on; auto-cleared.
// - Run write with comparator off leaves zero.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control
	import sar_adc_pkg::*;
#(
	parameter int EXT_CHANNELS = 11
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic [19:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWrData,
	input wire logic [7:0] sfrWrMask,
	output logic [15:0] sfrRdData,
	input wire logic compHigh,
	output logic [9:0] tapCode,
	output logic sampleHold,
	output logic comparatorOn,
	output logic [4:0] channelSelect,
	output logic [10:0] pinAnalogSelect,
	output logic conversionEndIrq
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [7:0] peripheralClockEnable_q;
	logic [7:0] converterModeZero_q;
	logic [7:0] converterModeTwo_q;
	logic [7:0] channelSelectRegister_q;
	logic [7:0] converterTestRegister_q;
	logic [15:0] conversionResultWide_q;
	logic [7:0] conversionResultByte_q;
	logic [9:0] sar_q;
	logic [3:0] bitIdx_q;
	logic [4:0] waitCnt_q;
	seq_state_e state_q;
	logic converterClockEnable;
	logic conversionRun;
	logic comparatorEnable;
	logic resolutionSelect;
	logic compSync;
	logic [3:0] lastBit;
	logic bitDone;
	logic conversionDone;
	logic startConv;
	logic runWrite;
	logic wrModeZero;
	logic [7:0] modeZeroMerged;

	// ------------------------------------------------------------------
	// Decode of control fields
	// ------------------------------------------------------------------
	// Fields that steer the sequencer and the analog side.
	assign converterClockEnable = peripheralClockEnable_q[CLK_EN_BIT];
	assign conversionRun = converterModeZero_q[RUN_BIT];
	assign comparatorEnable = converterModeZero_q[COMP_EN_BIT];
	assign resolutionSelect = converterModeTwo_q[RES_SEL_BIT];
	assign lastBit = resolutionSelect ? LAST_BIT_NARROW : LAST_BIT_WIDE;
	assign bitDone = (state_q == ST_COMPARE) && (waitCnt_q == COMPARE_LAST);
	assign conversionDone = (state_q == ST_FINISH);
	assign wrModeZero = sfrWrite && converterClockEnable && (sfrAddr == ADDR_MODE_ZERO);
	assign modeZeroMerged = mergeBits(converterModeZero_q, sfrWrData, sfrWrMask);
	assign runWrite = wrModeZero && sfrWrMask[RUN_BIT] && sfrWrData[RUN_BIT];
	// A start needs the comparator already on and no conversion under way.
	// A write that also drops the comparator enable is no start either.
	assign startConv = runWrite && comparatorEnable && modeZeroMerged[COMP_EN_BIT]
		&& !conversionRun;

	// ------------------------------------------------------------------
	// Comparator input synchroniser
	// ------------------------------------------------------------------
	comp_sync compSyncInst (
		.clk(clk),
		.reset(reset),
		.clkEn(clkEn),
		.asyncIn(compHigh),
		.syncOut(compSync)
	);

	// ------------------------------------------------------------------
	// Peripheral clock enable register
	// ------------------------------------------------------------------
	// Accepts single-bit and whole-byte writes through the write mask.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			peripheralClockEnable_q <= RESET_BYTE;
		end else if (clkEn && sfrWrite && (sfrAddr == ADDR_PER_CLK_EN)) begin
			peripheralClockEnable_q <= mergeBits(peripheralClockEnable_q, sfrWrData,
				sfrWrMask);
		end
	end

	// ------------------------------------------------------------------
	// Mode register zero: run and comparator control
	// ------------------------------------------------------------------
	// The run bit is set only by a legal start and cleared by software or at the end.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			converterModeZero_q <= RESET_BYTE;
		end else if (clkEn) begin
			if (!converterClockEnable) begin
				converterModeZero_q <= RESET_BYTE;
			end else if (wrModeZero) begin
				converterModeZero_q <= modeZeroMerged & MODE_ZERO_MASK;
				// A run bit at one is kept only for a legal start or a running conversion.
				converterModeZero_q[RUN_BIT] <= (startConv || (conversionRun
					&& modeZeroMerged[RUN_BIT])) && modeZeroMerged[COMP_EN_BIT]
					&& !conversionDone;
			end else if (conversionDone) begin
				converterModeZero_q[RUN_BIT] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Mode register two, channel select and test register
	// ------------------------------------------------------------------
	// Plain software registers, held at reset while the converter clock is off.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			converterModeTwo_q <= RESET_BYTE;
			channelSelectRegister_q <= RESET_BYTE;
			converterTestRegister_q <= RESET_BYTE;
		end else if (clkEn) begin
			if (!converterClockEnable) begin
				converterModeTwo_q <= RESET_BYTE;
				channelSelectRegister_q <= RESET_BYTE;
				converterTestRegister_q <= RESET_BYTE;
			end else if (sfrWrite) begin
				if (sfrAddr == ADDR_MODE_TWO) begin
					converterModeTwo_q <= mergeBits(converterModeTwo_q, sfrWrData,
						sfrWrMask) & MODE_TWO_MASK;
				end
				if (sfrAddr == ADDR_CHANNEL_SEL) begin
					channelSelectRegister_q <= mergeBits(channelSelectRegister_q,
						sfrWrData, sfrWrMask) & CHANNEL_MASK;
				end
				if (sfrAddr == ADDR_TEST_REG) begin
					converterTestRegister_q <= mergeBits(converterTestRegister_q,
						sfrWrData, sfrWrMask);
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	// Samples, then decides one approximation bit per compare slot from the top down.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_IDLE;
			sar_q <= SAR_CLEAR;
			bitIdx_q <= SAR_TOP_BIT;
			waitCnt_q <= COUNT_ZERO;
		end else if (clkEn) begin
			if (!converterClockEnable || (wrModeZero
				&& !(modeZeroMerged[RUN_BIT] && modeZeroMerged[COMP_EN_BIT]))) begin
				// Clock off, software stop or comparator off aborts any conversion.
				state_q <= ST_IDLE;
				sar_q <= SAR_CLEAR;
				bitIdx_q <= SAR_TOP_BIT;
				waitCnt_q <= COUNT_ZERO;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						waitCnt_q <= COUNT_ZERO;
						if (startConv) begin
							state_q <= ST_SAMPLE;
							sar_q <= SAR_CLEAR;
						end
					end
					ST_SAMPLE: begin
						if (waitCnt_q == SAMPLE_LAST) begin
							waitCnt_q <= COUNT_ZERO;
							state_q <= ST_COMPARE;
							// First trial puts the tap at half supply.
							sar_q <= SAR_FIRST_TRIAL;
							bitIdx_q <= SAR_TOP_BIT;
						end else begin
							waitCnt_q <= waitCnt_q + 5'h01;
						end
					end
					ST_COMPARE: begin
						if (bitDone) begin
							waitCnt_q <= COUNT_ZERO;
							// Bit stays at one when the input is at or above the tap.
							sar_q[bitIdx_q] <= compSync;
							if (bitIdx_q == lastBit) begin
								state_q <= ST_FINISH;
							end else begin
								// Next trial bit; tap now depends on bits already decided.
								sar_q[bitIdx_q - 4'h1] <= 1'b1;
								bitIdx_q <= bitIdx_q - 4'h1;
							end
						end else begin
							waitCnt_q <= waitCnt_q + 5'h01;
						end
					end
					ST_FINISH: begin
						state_q <= ST_IDLE;
						bitIdx_q <= SAR_TOP_BIT;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------------
	// Loaded from the approximation register when a conversion finishes.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conversionResultWide_q <= RESET_WORD;
			conversionResultByte_q <= RESET_BYTE;
		end else if (clkEn) begin
			if (!converterClockEnable) begin
				conversionResultWide_q <= RESET_WORD;
				conversionResultByte_q <= RESET_BYTE;
			end else if (conversionDone) begin
				conversionResultWide_q <= {sar_q, WIDE_PAD};
				conversionResultByte_q <= sar_q[9:2];
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt request and register read port
	// ------------------------------------------------------------------
	// One-cycle end pulse and registered read data; unmapped addresses read zero.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			conversionEndIrq <= 1'b0;
			sfrRdData <= RESET_WORD;
		end else if (clkEn) begin
			conversionEndIrq <= conversionDone && converterClockEnable;
			unique case (sfrAddr)
				ADDR_PER_CLK_EN: sfrRdData <= {8'h00, peripheralClockEnable_q};
				ADDR_MODE_ZERO: sfrRdData <= {8'h00, converterModeZero_q};
				ADDR_MODE_TWO: sfrRdData <= {8'h00, converterModeTwo_q};
				ADDR_RESULT_WIDE: sfrRdData <= conversionResultWide_q;
				ADDR_RESULT_BYTE: sfrRdData <= {8'h00, conversionResultByte_q};
				ADDR_CHANNEL_SEL: sfrRdData <= {8'h00, channelSelectRegister_q};
				ADDR_TEST_REG: sfrRdData <= {8'h00, converterTestRegister_q};
				default: sfrRdData <= RESET_WORD;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Analog side controls
	// ------------------------------------------------------------------
	// Tap code, sample-hold and mux select; only the selected pin leaves port use.
	assign tapCode = sar_q;
	assign sampleHold = (state_q == ST_SAMPLE);
	assign comparatorOn = comparatorEnable;
	assign channelSelect = channelSelectRegister_q[4:0];

	// One-hot pin claim, limited to the external channel count of the product.
	always_comb begin
		pinAnalogSelect = 11'h000;
		for (int i = 0; i < MAX_EXT_CHANNELS; i++) begin
			pinAnalogSelect[i] = (i < EXT_CHANNELS) && conversionRun
				&& (channelSelectRegister_q[4:0] == 5'(i));
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence legalStart;
		clkEn && startConv;
	endsequence

	sequence sampledThenFirstTrial;
		(state_q == ST_SAMPLE) ##1 (state_q == ST_COMPARE && sar_q == SAR_FIRST_TRIAL);
	endsequence

	property runOffWithoutComparator;
		@(posedge clk) disable iff (reset)
			(clkEn && wrModeZero && !comparatorEnable && !conversionRun) |=> !conversionRun;
	endproperty

	run_blocked_a: assert property (runOffWithoutComparator)
		else $error("run bit set while comparator was off");

	run_start_a: assert property (@(posedge clk) disable iff (reset)
		legalStart |=> conversionRun && (state_q == ST_SAMPLE))
		else $error("legal start did not set run bit");

	first_trial_a: assert property (@(posedge clk) disable iff (reset)
		(clkEn && state_q == ST_SAMPLE && waitCnt_q == SAMPLE_LAST && converterClockEnable
		&& !wrModeZero) |=> (sar_q == SAR_FIRST_TRIAL && bitIdx_q == SAR_TOP_BIT))
		else $error("first trial not at half supply");

	second_trial_a: assert property (@(posedge clk) disable iff (reset)
		(clkEn && bitDone && bitIdx_q == SAR_TOP_BIT && !wrModeZero && converterClockEnable)
		|=> (sar_q[8] && sar_q[9] == $past(compSync) && bitIdx_q == 4'h8))
		else $error("bit eight trial not set after top bit");

	narrow_stop_a: assert property (@(posedge clk) disable iff (reset)
		(conversionDone && resolutionSelect) |-> (sar_q[1:0] == 2'b00))
		else $error("narrow conversion decided low bits");

	wide_result_a: assert property (@(posedge clk) disable iff (reset)
		(clkEn && conversionDone && converterClockEnable)
		|=> (conversionResultWide_q == {$past(sar_q), WIDE_PAD}))
		else $error("wide result not loaded left aligned");

	byte_result_a: assert property (@(posedge clk) disable iff (reset)
		(clkEn && conversionDone && converterClockEnable)
		|=> (conversionResultByte_q == conversionResultWide_q[15:8]))
		else $error("byte result disagrees with wide result");

	end_irq_a: assert property (@(posedge clk) disable iff (reset)
		conversionEndIrq |-> (!conversionRun && state_q == ST_IDLE))
		else $error("end request while still converting");

	clock_off_a: assert property (@(posedge clk) disable iff (reset)
		(clkEn && !converterClockEnable) |=> (converterModeZero_q == RESET_BYTE
		&& conversionResultWide_q == RESET_WORD && state_q == ST_IDLE))
		else $error("converter not held in reset with clock off");

	pin_claim_a: assert property (@(posedge clk) disable iff (reset)
		$onehot0(pinAnalogSelect))
		else $error("more than one pin claimed for conversion");
endmodule // sar_adc_control
`default_nettype wire

/* File: sar_adc_pkg.sv */
// Package with register map, field layout and timing constants of the converter control.
package sar_adc_pkg;

	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [19:0] ADDR_PER_CLK_EN = 20'hF00F0;
	localparam logic [19:0] ADDR_MODE_ZERO = 20'hFFE30;
	localparam logic [19:0] ADDR_MODE_TWO = 20'hFFE31;
	localparam logic [19:0] ADDR_RESULT_WIDE = 20'hFFE32;
	localparam logic [19:0] ADDR_RESULT_BYTE = 20'hFFE34;
	localparam logic [19:0] ADDR_CHANNEL_SEL = 20'hFFE35;
	localparam logic [19:0] ADDR_TEST_REG = 20'hFFE36;

	// ------------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam int CLK_EN_BIT = 5;
	localparam int RUN_BIT = 7;
	localparam int COMP_EN_BIT = 0;
	localparam int RES_SEL_BIT = 0;
	// Writable bits of mode register zero: run, two speed bits, level bit, comparator enable.
	localparam logic [7:0] MODE_ZERO_MASK = 8'h9B;
	localparam logic [7:0] CHANNEL_MASK = 8'h1F;
	localparam logic [7:0] MODE_TWO_MASK = 8'h01;
	localparam logic [5:0] WIDE_PAD = 6'h00;

	// ------------------------------------------------------------------
	// Channel codes and approximation layout
	// ------------------------------------------------------------------
	localparam int MAX_EXT_CHANNELS = 11;
	localparam logic [4:0] CH_TEMP_SENSOR = 5'h10;
	localparam logic [4:0] CH_INT_REFERENCE = 5'h11;
	localparam logic [4:0] CH_TOUCH_CAP = 5'h12;
	localparam int SAR_WIDTH = 10;
	localparam logic [3:0] SAR_TOP_BIT = 4'h9;
	localparam logic [3:0] LAST_BIT_WIDE = 4'h0;
	localparam logic [3:0] LAST_BIT_NARROW = 4'h2;
	localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
	localparam logic [9:0] SAR_CLEAR = 10'h000;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SAMPLE_TIME_NS = 1000;
	localparam int COMPARE_TIME_NS = 250;
	localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int COMPARE_CYCLES = (COMPARE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYCLES - 1);
	localparam logic [4:0] COMPARE_LAST = 5'(COMPARE_CYCLES - 1);
	localparam logic [4:0] COUNT_ZERO = 5'h00;

	// Conversion sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_COMPARE = 2'b10,
		ST_FINISH = 2'b11
	} seq_state_e;

	// Applies a masked write: bits outside the mask keep their old value.
	function automatic logic [7:0] mergeBits(input logic [7:0] oldVal, input logic [7:0] newVal,
		input logic [7:0] mask);
		return (oldVal & ~mask) | (newVal & mask);
	endfunction

endpackage

/* File: comp_sync.sv */
// Three-stage synchroniser with agreement filter for the analog comparator decision.
`timescale 1ns/1ps
`default_nettype none
module comp_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire logic asyncIn,
	output logic syncOut
);
	logic stage1_q;
	logic stage2_q;
	logic stage3_q;

	// ------------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------------
	// The first stage is read only by the second stage.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
			stage3_q <= 1'b0;
		end else if (clkEn) begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	// ------------------------------------------------------------------
	// Agreement filter
	// ------------------------------------------------------------------
	// A change is accepted only once the second and third stages agree.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			syncOut <= 1'b0;
		end else if (clkEn && (stage2_q == stage3_q)) begin
			syncOut <= stage3_q;
		end
	end
endmodule // comp_sync
`default_nettype wire

/* File: analog_front_model.sv */
// Behavioural analog front end: sample-hold of the selected source and the tap comparator.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
	input wire logic clk,
	input wire logic [31:0][9:0] levels,
	input wire logic [4:0] channelSelect,
	input wire logic sampleHold,
	input wire logic comparatorOn,
	input wire logic [9:0] tapCode,
	output logic compHigh
);
	logic [9:0] heldLevel = 10'h000;
	logic noise = 1'b0;

	// Captures the selected source while the sample switch is closed; the noise bit flips.
	always @(posedge clk) begin
		if (sampleHold) begin
			heldLevel <= levels[channelSelect];
		end
		noise <= ~noise;
	end

	// An idle or sampling comparator gives a changing level, never a stale decision.
	assign compHigh = (comparatorOn && !sampleHold) ? (heldLevel >= tapCode) : noise;
endmodule // analog_front_model
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench of the converter control against a behavioural analog front end.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sar_adc_pkg::*;
	localparam int EXT = 7;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clkEn = 1'b1;
	logic [19:0] sfrAddr = 20'h00000;
	logic sfrWrite = 1'b0;
	logic [7:0] sfrWrData = 8'h00;
	logic [7:0] sfrWrMask = 8'h00;
	logic [15:0] sfrRdData;
	logic compHigh;
	logic [9:0] tapCode;
	logic sampleHold;
	logic comparatorOn;
	logic conversionEndIrq;
	logic [4:0] channelSelect;
	logic [10:0] pinAnalogSelect;
	logic [31:0][9:0] levels = '0;
	logic rdTag = 1'b0;
	logic [15:0] rdQ[$];
	int irqQ = 0;
	int failures = 0;
	int cmp_count = 0;

	// Free-running bench clock of 50 ns.
	always #25 clk = ~clk;

	sar_adc_control #(.EXT_CHANNELS(EXT)) sar_adc_control_inst (
		.clk(clk), .reset(reset), .clkEn(clkEn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
		.sfrWrData(sfrWrData), .sfrWrMask(sfrWrMask), .sfrRdData(sfrRdData),
		.compHigh(compHigh), .tapCode(tapCode), .sampleHold(sampleHold),
		.comparatorOn(comparatorOn), .channelSelect(channelSelect),
		.pinAnalogSelect(pinAnalogSelect), .conversionEndIrq(conversionEndIrq)
	);

	analog_front_model analog_front_model_inst (
		.clk(clk), .levels(levels), .channelSelect(channelSelect), .sampleHold(sampleHold),
		.comparatorOn(comparatorOn), .tapCode(tapCode), .compHigh(compHigh)
	);

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	// Counts a comparison and reports a mismatch at once.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One masked register write, taken at the edge after it is set up.
	task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m);
		@(posedge clk);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrMask <= m;
		sfrWrite <= 1'b1;
		@(posedge clk);
		sfrWrite <= 1'b0;
	endtask

	// Presents a read address and notes the expected data for the watcher.
	task automatic rd(input logic [19:0] a, input logic [15:0] exp);
		@(posedge clk);
		sfrAddr <= a;
		rdTag <= 1'b1;
		rdQ.push_back(exp);
		@(posedge clk);
		rdTag <= 1'b0;
	endtask

	// Compares read data one cycle after its address edge and checks each end pulse.
	always @(posedge clk) begin : watch
		logic tagSeen;
		tagSeen = rdTag;
		#1;
		if (tagSeen) begin
			check(sfrRdData, rdQ.pop_front());
		end
		if (conversionEndIrq === 1'b1) begin
			check(16'(irqQ), 16'h0001);
			irqQ = 0;
		end
	end

	// A hang anywhere counts as a mismatch and closes the run.
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [4:0] ch;
		logic [9:0] lvl;
		logic [9:0] res;
		logic narrow;
		int n;
		void'($urandom(12));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(ADDR_PER_CLK_EN, 16'h0000);
		rd(ADDR_MODE_ZERO, 16'h0000);
		rd(20'hFFE3F, 16'h0000);
		wr(ADDR_CHANNEL_SEL, 8'h03, 8'hFF);
		rd(ADDR_CHANNEL_SEL, 16'h0000);
		wr(ADDR_PER_CLK_EN, 8'h20, 8'h20);
		rd(ADDR_PER_CLK_EN, 16'h0020);
		wr(ADDR_MODE_ZERO, 8'h80, 8'h80);
		repeat (30) @(posedge clk);
		rd(ADDR_MODE_ZERO, 16'h0000);
		// Conversions over random sources, boundary levels first, both resolutions.
		for (int i = 0; i < 12; i++) begin
			n = $urandom % (EXT + 3);
			ch = (n < EXT) ? 5'(n) : 5'(CH_TEMP_SENSOR + 5'(n - EXT));
			case (i)
				0: lvl = 10'h3FF;
				1: lvl = 10'h000;
				2: lvl = 10'h200;
				3: lvl = 10'h1FF;
				default: lvl = 10'($urandom);
			endcase
			narrow = i[0];
			levels[ch] <= lvl;
			wr(ADDR_MODE_TWO, {7'h00, narrow}, 8'hFF);
			wr(ADDR_CHANNEL_SEL, {3'h0, ch}, 8'hFF);
			wr(ADDR_MODE_ZERO, 8'h01, 8'hFF);
			irqQ = 1;
			wr(ADDR_MODE_ZERO, 8'h81, 8'h80);
			repeat (2) @(posedge clk);
			#1;
			check(16'(sampleHold), 16'h0001);
			check(16'(channelSelect), 16'(ch));
			check(16'(pinAnalogSelect), (ch < EXT) ? 16'(1 << ch) : 16'h0000);
			check(16'(comparatorOn), 16'h0001);
			// One conversion is frozen for a while by the clock enable in mid approximation.
			if (i == 5) begin
				repeat (30) @(posedge clk);
				clkEn <= 1'b0;
				repeat (7) @(posedge clk);
				clkEn <= 1'b1;
			end
			n = 0;
			while (conversionEndIrq !== 1'b1 && n < 200) begin
				@(posedge clk);
				#1;
				n++;
			end
			if (n == 200) begin
				failures++;
				test_done();
			end
			res = narrow ? {lvl[9:2], 2'b00} : lvl;
			rd(ADDR_RESULT_WIDE, {res, 6'h00});
			rd(ADDR_RESULT_BYTE, {8'h00, res[9:2]});
			rd(ADDR_MODE_ZERO, 16'h0001);
			#1;
			check(16'(pinAnalogSelect), 16'h0000);
		end
		// A conversion stopped in mid-run gives no end pulse.
		wr(ADDR_MODE_ZERO, 8'h81, 8'h80);
		repeat (15) @(posedge clk);
		wr(ADDR_MODE_ZERO, 8'h00, 8'h80);
		repeat (120) @(posedge clk);
		rd(ADDR_RESULT_WIDE, {res, 6'h00});
		rd(ADDR_MODE_ZERO, 16'h0001);
		// Withdrawing the clock supply clears the converter registers.
		wr(ADDR_PER_CLK_EN, 8'h00, 8'h20);
		rd(ADDR_RESULT_WIDE, 16'h0000);
		rd(ADDR_MODE_ZERO, 16'h0000);
		wr(ADDR_PER_CLK_EN, 8'h20, 8'hFF);
		wr(ADDR_MODE_TWO, 8'h01, 8'h01);
		rd(ADDR_MODE_TWO, 16'h0001);
		repeat (5) @(posedge clk);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
